// ---- dovt_regs.vh ----
// Purpose : constants for the data-enable-only video timing source
// Assumes : included by every design file of the block
// Notes   : times are in clk cycles unless named otherwise
`ifndef DOVT_REGS_VH
`define DOVT_REGS_VH

// ==========================================================
// clocking
`define DOVT_CLK_MHZ          200
`define DOVT_PIX_DIV          3
`define DOVT_PIX_MIN_MHZ      60
`define DOVT_PIX_MAX_MHZ      80

// ==========================================================
// line timing, in pixel clocks
`define DOVT_H_ACTIVE         11'h3C0
`define DOVT_H_TOTAL_MIN      11'h406
`define DOVT_H_TOTAL_TYP      11'h44C
`define DOVT_H_TOTAL_MAX      11'h52D
`define DOVT_H_BLANK_MIN      11'h046
`define DOVT_H_BLANK_MAX      11'h16D

// ==========================================================
// frame timing, in lines
`define DOVT_V_ACTIVE         11'h438
`define DOVT_V_TOTAL_MIN      11'h442
`define DOVT_V_TOTAL_50HZ     11'h4BC
`define DOVT_V_TOTAL_MAX      11'h5C8
`define DOVT_V_BLANK_MIN      11'h00A
`define DOVT_V_BLANK_MAX      11'h190

// ==========================================================
// power sequencing
`define DOVT_SEQ_DELAY_US     1000
`define DOVT_ST_OFF           3'h0
`define DOVT_ST_PWR_UP        3'h1
`define DOVT_ST_LINK_UP       3'h2
`define DOVT_ST_RUN           3'h3
`define DOVT_ST_LIGHT_DN      3'h4
`define DOVT_ST_LINK_DN       3'h5

`endif

// ---- dovt_raster.v ----
// Purpose : horizontal and vertical raster counters for the panel stream
// Assumes : step is a one-cycle pulse once per pixel clock period
// Notes   : totals are clamped and taken only while stopped or at a frame boundary
`timescale 1ns/100ps
`include "dovt_regs.vh"

module dovt_raster #(
  parameter W = 11
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         run,
  input  wire         step,
  input  wire [W-1:0] line_total_cycles,
  input  wire [W-1:0] frame_total_lines,
  output reg  [W-1:0] h_cnt,
  output reg  [W-1:0] v_cnt,
  output wire         active
);

  reg [W-1:0] h_total;
  reg [W-1:0] v_total;

  // ==========================================================
  // clamp helper
  function [W-1:0] clamp;
    input [W-1:0] val;
    input [W-1:0] lo;
    input [W-1:0] hi;
    begin
      clamp = (val < lo) ? lo : ((val > hi) ? hi : val);
    end
  endfunction

  // de only inside the active window of an active line
  assign active = run && (h_cnt < `DOVT_H_ACTIVE) && (v_cnt < `DOVT_V_ACTIVE);

  // ==========================================================
  // counters
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // defaults give 50 Hz: 1100 x 1212 at clk/3, inside both limits
      h_cnt   <= 11'h000;
      v_cnt   <= 11'h000;
      h_total <= `DOVT_H_TOTAL_TYP;
      v_total <= `DOVT_V_TOTAL_50HZ;
    end else if (!run) begin
      h_cnt   <= 11'h000;
      v_cnt   <= 11'h000;
      h_total <= clamp(line_total_cycles, `DOVT_H_TOTAL_MIN, `DOVT_H_TOTAL_MAX);
      v_total <= clamp(frame_total_lines, `DOVT_V_TOTAL_MIN, `DOVT_V_TOTAL_MAX);
    end else if (step) begin
      if (h_cnt == h_total - 11'h001) begin
        h_cnt <= 11'h000;
        if (v_cnt == v_total - 11'h001) begin
          v_cnt <= 11'h000;
          // totals change only between frames so the panel sees steady timing
          h_total <= clamp(line_total_cycles, `DOVT_H_TOTAL_MIN, `DOVT_H_TOTAL_MAX);
          v_total <= clamp(frame_total_lines, `DOVT_V_TOTAL_MIN, `DOVT_V_TOTAL_MAX);
        end else begin
          v_cnt <= v_cnt + 11'h001;
        end
      end else begin
        h_cnt <= h_cnt + 11'h001;
      end
    end
  end

endmodule

// ---- dovt_source.v ----
// Purpose : video source driving a 1080-line panel in data-enable-only mode
// Assumes : pixel data comes from logic on clk; panel supply switched by this block
// Notes   : pixel clock is clk divided by PIX_DIV; defaults give 66.7 MHz, 50 Hz
`timescale 1ns/100ps
`include "dovt_regs.vh"

module dovt_source #(
  parameter PIX_DIV          = `DOVT_PIX_DIV,
  parameter SEQ_DELAY_CYCLES = `DOVT_SEQ_DELAY_US * `DOVT_CLK_MHZ,
  parameter CW               = 20
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        power_on_req,
  input  wire        format_vesa,
  input  wire [10:0] line_total_cycles,
  input  wire [10:0] frame_total_lines,
  input  wire [7:0]  pixel_red,
  input  wire [7:0]  pixel_green,
  input  wire [7:0]  pixel_blue,
  output reg         pixel_take,
  output reg         panel_power_en,
  output reg         backlight_en,
  output reg         link_oe,
  output reg         pixel_clk,
  output reg         data_enable,
  output reg         hsync,
  output reg         vsync,
  output reg  [7:0]  red,
  output reg  [7:0]  green,
  output reg  [7:0]  blue,
  output reg         link_format_select,
  output reg         frame_start,
  output reg         running
);

  localparam integer  DIV_LAST_I = PIX_DIV - 1;
  localparam integer  DIV_HIGH_I = (PIX_DIV + 1) / 2;
  localparam integer  SEQ_LAST_I = SEQ_DELAY_CYCLES - 1;
  localparam [7:0]    DIV_LAST   = DIV_LAST_I[7:0];
  localparam [7:0]    DIV_HIGH   = DIV_HIGH_I[7:0];
  localparam [7:0]    STEP_AT    = DIV_HIGH - 8'h01;
  localparam [CW-1:0] SEQ_LAST   = SEQ_LAST_I[CW-1:0];

  reg  [7:0]    div_cnt;
  reg  [7:0]    next_div_cnt;
  reg           step;
  reg  [2:0]    state;
  reg  [2:0]    next_state;
  reg  [CW-1:0] wait_cnt;
  reg           wait_clr;
  reg           run;
  wire          wait_done;
  wire [10:0]   h_cnt;
  wire [10:0]   v_cnt;
  wire          active;

  assign wait_done = (wait_cnt == SEQ_LAST);

  // ==========================================================
  // pixel clock divider, from clk only
  // fixed ratio of one steady clock: no spread, so zero deviation
  always @* begin
    next_div_cnt = (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      step    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      // step lands on the falling pixel clock edge so data is stable at rising
      step    <= (next_div_cnt == STEP_AT);
    end
  end

  // ==========================================================
  // raster counters
  dovt_raster #(
    .W (11)
  ) u_raster (
    .clk               (clk),
    .rst_n             (rst_n),
    .run               (run),
    .step              (step),
    .line_total_cycles (line_total_cycles),
    .frame_total_lines (frame_total_lines),
    .h_cnt             (h_cnt),
    .v_cnt             (v_cnt),
    .active            (active)
  );

  // ==========================================================
  // power sequencer
  always @* begin
    next_state = state;
    wait_clr   = 1'b0;
    case (state)
      `DOVT_ST_OFF: begin
        if (power_on_req) begin
          next_state = `DOVT_ST_PWR_UP;
          wait_clr   = 1'b1;
        end
      end
      `DOVT_ST_PWR_UP: begin
        // link stays low until the supply has settled
        if (wait_done) begin
          next_state = `DOVT_ST_LINK_UP;
          wait_clr   = 1'b1;
        end
      end
      `DOVT_ST_LINK_UP: begin
        // backlight waits until the panel shows a valid picture
        if (!power_on_req) begin
          next_state = `DOVT_ST_LINK_DN;
          wait_clr   = 1'b1;
        end else if (wait_done) begin
          next_state = `DOVT_ST_RUN;
        end
      end
      `DOVT_ST_RUN: begin
        if (!power_on_req) begin
          next_state = `DOVT_ST_LIGHT_DN;
          wait_clr   = 1'b1;
        end
      end
      `DOVT_ST_LIGHT_DN: begin
        // backlight is dark before the panel loses its stream
        if (wait_done) begin
          next_state = `DOVT_ST_LINK_DN;
          wait_clr   = 1'b1;
        end
      end
      `DOVT_ST_LINK_DN: begin
        if (wait_done) begin
          next_state = `DOVT_ST_OFF;
        end
      end
      default: begin
        next_state = `DOVT_ST_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= `DOVT_ST_OFF;
      wait_cnt <= {CW{1'b0}};
    end else begin
      state <= next_state;
      if (wait_clr) begin
        wait_cnt <= {CW{1'b0}};
      end else if (!wait_done) begin
        wait_cnt <= wait_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // sequencer outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_power_en     <= 1'b0;
      backlight_en       <= 1'b0;
      link_oe            <= 1'b0;
      run                <= 1'b0;
      running            <= 1'b0;
      link_format_select <= 1'b0;
    end else begin
      panel_power_en <= (next_state != `DOVT_ST_OFF);
      backlight_en   <= (next_state == `DOVT_ST_RUN);
      // driven for the whole powered time, never floating
      link_oe        <= (next_state != `DOVT_ST_OFF);
      run            <= (next_state == `DOVT_ST_LINK_UP) || (next_state == `DOVT_ST_RUN) ||
                        (next_state == `DOVT_ST_LIGHT_DN);
      running        <= (next_state == `DOVT_ST_RUN);
      // format pin low while unpowered, else high selects VESA
      link_format_select <= (next_state != `DOVT_ST_OFF) && format_vesa;
    end
  end

  // ==========================================================
  // link pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_clk   <= 1'b0;
      data_enable <= 1'b0;
      hsync       <= 1'b0;
      vsync       <= 1'b0;
      red         <= 8'h00;
      green       <= 8'h00;
      blue        <= 8'h00;
      pixel_take  <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      // syncs never toggle: panel frames on data enable alone
      hsync       <= 1'b0;
      vsync       <= 1'b0;
      pixel_clk   <= run && (next_div_cnt < DIV_HIGH);
      pixel_take  <= step && active;
      frame_start <= step && run && (h_cnt == 11'h000) && (v_cnt == 11'h000);
      if (!run) begin
        data_enable <= 1'b0;
        red         <= 8'h00;
        green       <= 8'h00;
        blue        <= 8'h00;
      end else if (step) begin
        // 960 enabled pixels on each of 1080 lines
        data_enable <= active;
        // codes pass unchanged: higher code is brighter
        red         <= active ? pixel_red   : 8'h00;
        green       <= active ? pixel_green : 8'h00;
        blue        <= active ? pixel_blue  : 8'h00;
      end
    end
  end

endmodule

// ---- dovt_source_asserts.sv ----
// Purpose: port checks for dovt_source
// Assumes: one clock domain
// Notes  : sequencing delay is at least 8 clk
`timescale 1ns/100ps
module dovt_source_asserts (
  input wire       clk,
  input wire       rst_n,
  input wire       power_on_req,
  input wire       pixel_take,
  input wire       panel_power_en,
  input wire       backlight_en,
  input wire       link_oe,
  input wire       pixel_clk,
  input wire       data_enable,
  input wire       hsync,
  input wire       vsync,
  input wire [7:0] red,
  input wire [7:0] green,
  input wire [7:0] blue,
  input wire       running,
  input wire       frame_start
);
  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire dark = (red == 8'h00) && (green == 8'h00) && (blue == 8'h00);
  sequence s_pwr_up; !panel_power_en ##1 panel_power_en; endsequence
  sequence s_lamp_down; !backlight_en && !running ##1 panel_power_en [*7]; endsequence
  a_sync_low: assert property (!hsync && !vsync)
    else $error("sync high");
  a_oe_tracks_power: assert property (link_oe == panel_power_en)
    else $error("link enable differs from supply");
  a_off_quiet: assert property (!panel_power_en |-> !data_enable && !pixel_clk && dark)
    else $error("link driven while off");
  a_lamp_needs_panel: assert property (backlight_en |-> panel_power_en)
    else $error("lamp without panel");
  a_lamp_down_first: assert property (running && !power_on_req |=> s_lamp_down)
    else $error("lamp not off first");
  a_lamp_late: assert property (s_pwr_up |-> !backlight_en [*8])
    else $error("lamp too early");
  a_blank_dark: assert property (!data_enable |-> dark)
    else $error("colour outside enable");
  a_take_on_de: assert property (pixel_take |-> data_enable && !pixel_clk)
    else $error("take outside enable");
  a_pix_period: assert property ($rose(pixel_clk) && running |-> ##3 $rose(pixel_clk))
    else $error("pixel clock period not three clk");
  a_frame_first_pixel: assert property (frame_start |-> pixel_take && data_enable)
    else $error("frame start off the first pixel");
endmodule
bind dovt_source dovt_source_asserts u_dovt_source_asserts (
  .clk(clk), .rst_n(rst_n), .power_on_req(power_on_req), .pixel_take(pixel_take),
  .panel_power_en(panel_power_en), .backlight_en(backlight_en), .link_oe(link_oe),
  .pixel_clk(pixel_clk), .data_enable(data_enable), .hsync(hsync), .vsync(vsync),
  .red(red), .green(green), .blue(blue), .running(running), .frame_start(frame_start));

// ---- dovt_panel_model.sv ----
// Purpose: panel end of the pixel link
// Assumes: link sampled on rising pixel_clk
// Notes  : run lengths in pixel clocks
`timescale 1ns/100ps
module dovt_panel_model (
  input  wire        rst_n,
  input  wire        pixel_clk,
  input  wire        data_enable,
  input  wire        hsync,
  input  wire        vsync,
  input  wire [7:0]  red,
  input  wire [7:0]  green,
  input  wire [7:0]  blue,
  output reg  [10:0] de_len,
  output reg  [10:0] blank_len,
  output reg  [23:0] last_pix,
  output reg         sync_bad
);
  // ==========================================
  // raster measurement
  reg [10:0] run;
  reg        de_q;
  always @(posedge pixel_clk or negedge rst_n) begin
    if (!rst_n) begin
      de_len <= 11'h000;
      blank_len <= 11'h000;
      last_pix <= 24'h000000;
      sync_bad <= 1'b0;
      run <= 11'h000;
      de_q <= 1'b0;
    end else begin
      de_q <= data_enable;
      sync_bad <= sync_bad | hsync | vsync;
      // framing by enable alone, syncs ignored
      if (data_enable != de_q) begin
        run <= 11'h001;
        if (de_q) de_len <= run;
        else blank_len <= run;
      end else begin
        run <= run + 11'h001;
      end
      if (data_enable) begin
        last_pix <= {red, green, blue}; // unsigned 8-bit code per colour, as sent
      end
    end
  end
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for dovt_source
// Assumes: sequencing delay cut to 20 clk
// Notes  : only a few lines of a frame fit the run
`timescale 1ns/100ps
module testbench;
  reg         clk, rst_n, req, fmt;
  reg  [10:0] ltot, ftot;
  reg  [7:0]  pr, pg, pb;
  wire        take, pwr, bl, oe, pck, de, hs, vs, fsel, run, sbad;
  wire [7:0]  r, g, b;
  wire [10:0] de_len, bk_len;
  wire [23:0] pix;
  integer     fails, n_compared, i;
  dovt_source #(.SEQ_DELAY_CYCLES(20)) u_dovt_source (
    .clk(clk), .rst_n(rst_n), .power_on_req(req), .format_vesa(fmt),
    .line_total_cycles(ltot), .frame_total_lines(ftot),
    .pixel_red(pr), .pixel_green(pg), .pixel_blue(pb), .pixel_take(take),
    .panel_power_en(pwr), .backlight_en(bl), .link_oe(oe), .pixel_clk(pck),
    .data_enable(de), .hsync(hs), .vsync(vs), .red(r), .green(g), .blue(b),
    .link_format_select(fsel), .frame_start(), .running(run));
  dovt_panel_model u_dovt_panel_model (.rst_n(rst_n), .pixel_clk(pck),
    .data_enable(de), .hsync(hs), .vsync(vs), .red(r), .green(g), .blue(b),
    .de_len(de_len), .blank_len(bk_len), .last_pix(pix), .sync_bad(sbad));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // sel high waits on the lamp, low on the supply
  task wait_on(input sel, input v, input integer lim);
    begin
      i = 0;
      while (((sel ? bl : pwr) !== v) && i < lim) begin
        @(posedge clk);
        i = i + 1;
      end
      if ((sel ? bl : pwr) !== v) begin
        fails = fails + 1;
        final_report;
      end
    end
  endtask
  // ==========================================
  // scenarios
  task t_idle;
    begin
      repeat (50) @(posedge clk);
      chk({pwr, bl, oe, pck, de, fsel, r, g, b}, 32'h0);
      $display("idle test done");
    end
  endtask
  task power_cycle(input f, input [10:0] lt, input [10:0] blank, input [23:0] rgb);
    begin
      @(posedge clk);
      fmt <= f;
      ltot <= lt;
      {pr, pg, pb} <= rgb;
      req <= 1'b1;
      wait_on(1'b0, 1'b1, 10);
      chk({bl, oe, fsel}, {2'b01, f});
      wait_on(1'b1, 1'b1, 100);
      chk({bl, run}, 2'b11);
      repeat (16000) @(posedge clk);
      chk(de_len, 11'h3C0);
      chk(bk_len, blank);
      chk(pix, rgb);
      chk(sbad, 1'b0);
      req <= 1'b0;
      wait_on(1'b1, 1'b0, 5);
      chk({pwr, run}, 2'b10);
      wait_on(1'b0, 1'b0, 100);
      @(posedge clk);
      chk({oe, pck, de, fsel, r, g, b}, 32'h0);
      $display("power cycle done format=%0d", f);
    end
  endtask
  initial begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    req = 1'b0;
    fmt = 1'b0;
    ltot = 11'h44C;
    ftot = 11'h4BC;
    {pr, pg, pb} = 24'h000000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_idle;
    power_cycle(1'b1, 11'h3E8, 11'h046, 24'hA53C0F);
    power_cycle(1'b0, 11'h7FF, 11'h16D, 24'hFF0080);
    final_report;
  end
endmodule
